// ===== rtl/eeops_top.sv
// serial eeprom slave: page write, ack polling, write protect, reads
`timescale 1ns/1ps
`default_nettype none
module eeops_top
    import eeops_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEF,
    parameter int INTERNAL_WRITE_CYCLE_TIME = INTERNAL_WRITE_CYCLE_TIME_DEF
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic wp,
    output logic busy
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(INTERNAL_WRITE_CYCLE_TIME + 1);

    eeops_if fb ();

    eeops_fe u_fe (
        .mclk(mclk),
        .rst_n(rst_n),
        .scl_pin(scl),
        .sda_pin(sda_i),
        .wp_pin(wp),
        .fb(fb)
    );

    function automatic logic [AW-1:0] addr_inc(input logic [AW-1:0] a);
        return a + 1'b1;
    endfunction : addr_inc

    // full address from upper bits of the address byte and the word byte
    function automatic logic [AW-1:0] mk_addr(input logic [1:0] up, input logic [7:0] w);
        logic [9:0] full;
        full = {up, w};
        return full[AW-1:0];
    endfunction : mk_addr

    eeops_state_t state_q;
    eeops_kind_t kind_q;
    logic [3:0] bcnt_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic rw_q;
    logic mack_q;
    logic wp_lat_q;
    logic [1:0] up_q;
    logic [AW-1:0] addr_q;
    logic [AW-PAGE_AW-1:0] page_q;
    logic [PAGE_AW-1:0] offs_q;
    logic [7:0] buf_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] vld_q;
    logic [7:0] mem_q [DEPTH];
    logic busy_q;
    logic [CW-1:0] cnt_q;
    logic sda_oe_q;
    logic sda_o_q;
    logic [7:0] rd_byte;
    logic byte_end;
    logic commit;

    assign rd_byte = mem_q[addr_q];
    assign byte_end = fb.scl_fall && bcnt_q == BYTE_BITS && !fb.start && !fb.stop;
    assign commit = fb.stop && |vld_q && !busy_q;

    // protocol engine
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            kind_q <= K_DEV;
            bcnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'b0;
            mack_q <= 1'b0;
            wp_lat_q <= 1'b0;
            up_q <= 2'h0;
            addr_q <= '0;
            page_q <= '0;
            offs_q <= '0;
            vld_q <= '0;
            sda_oe_q <= 1'b0;
        end else if (fb.stop) begin
            state_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
            vld_q <= '0;
            if (|vld_q) begin
                addr_q <= {page_q, offs_q};
            end
        end else if (fb.start) begin
            // a restart without stop drops any uncommitted page data
            state_q <= ST_RX;
            kind_q <= K_DEV;
            bcnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
            vld_q <= '0;
        end else begin
            case (state_q)
                ST_RX: begin
                    if (fb.scl_rise) begin
                        sh_q <= {sh_q[6:0], fb.sda_s};
                        bcnt_q <= bcnt_q + 4'h1;
                    end else if (byte_end) begin
                        bcnt_q <= 4'h0;
                        case (kind_q)
                            K_DEV: begin
                                if (sh_q[7:4] == DEV_CODE && !busy_q) begin
                                    rw_q <= sh_q[RW_POS];
                                    up_q <= (AW == 10) ? {sh_q[UPPER_HIGH_POS], sh_q[UPPER_LOW_POS]}
                                                       : {1'b0, sh_q[UPPER_LOW_POS]};
                                    sda_oe_q <= 1'b1;
                                    state_q <= ST_ACK;
                                end else begin
                                    state_q <= ST_IDLE;
                                end
                            end
                            K_WORD: begin
                                addr_q <= mk_addr(up_q, sh_q);
                                page_q <= (AW-PAGE_AW)'(mk_addr(up_q, sh_q) >> PAGE_AW);
                                offs_q <= sh_q[PAGE_AW-1:0];
                                sda_oe_q <= 1'b1;
                                state_q <= ST_ACK;
                            end
                            default: begin
                                if (wp_lat_q) begin
                                    state_q <= ST_IDLE;
                                end else begin
                                    buf_q[offs_q] <= sh_q;
                                    vld_q[offs_q] <= 1'b1;
                                    offs_q <= offs_q + 1'b1;
                                    sda_oe_q <= 1'b1;
                                    state_q <= ST_ACK;
                                end
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (fb.scl_fall) begin
                        bcnt_q <= 4'h0;
                        if (rw_q) begin
                            tx_q <= rd_byte;
                            sda_oe_q <= ~rd_byte[7];
                            state_q <= ST_TX;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q <= ST_RX;
                            kind_q <= (kind_q == K_DEV) ? K_WORD : K_DATA;
                            if (kind_q == K_WORD) begin
                                wp_lat_q <= fb.wp_s;
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (fb.scl_rise) begin
                        bcnt_q <= bcnt_q + 4'h1;
                    end else if (byte_end) begin
                        sda_oe_q <= 1'b0;
                        addr_q <= addr_inc(addr_q);
                        state_q <= ST_MACK;
                    end else if (fb.scl_fall) begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe_q <= ~tx_q[6];
                    end
                end
                ST_MACK: begin
                    if (fb.scl_rise) begin
                        mack_q <= ~fb.sda_s;
                    end else if (fb.scl_fall) begin
                        bcnt_q <= 4'h0;
                        if (mack_q) begin
                            tx_q <= rd_byte;
                            sda_oe_q <= ~rd_byte[7];
                            state_q <= ST_TX;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // array, commit and write timer; all buffered bytes of the page land in one cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= ERASED_BYTE;
            end
            busy_q <= 1'b0;
            cnt_q <= '0;
        end else if (commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (vld_q[i]) begin
                    mem_q[{page_q, PAGE_AW'(i)}] <= buf_q[i];
                end
            end
            busy_q <= 1'b1;
            cnt_q <= CW'(INTERNAL_WRITE_CYCLE_TIME - 1);
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // open drain: the line is only ever pulled low
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sda_o_q <= 1'b0;
        end else begin
            sda_o_q <= 1'b0;
        end
    end

    assign sda_o = sda_o_q;
    assign sda_oe = sda_oe_q;
    assign busy = busy_q;

    AST_PAGE_WRAP: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_RX && kind_q == K_DATA && byte_end && !wp_lat_q)
        |=> offs_q == PAGE_AW'($past(offs_q) + 1'b1) && vld_q[$past(offs_q)])
        else $error("page offset did not advance with wrap");
    AST_BUSY_NACK: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_RX && kind_q == K_DEV && byte_end && busy_q)
        |=> state_q == ST_IDLE && !sda_oe_q)
        else $error("address acknowledged while busy");
    AST_DEV_ACK: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_RX && kind_q == K_DEV && byte_end && !busy_q && sh_q[7:4] == DEV_CODE)
        |=> sda_oe_q && state_q == ST_ACK)
        else $error("matching address not acknowledged");
    AST_COMMIT: assert property (@(posedge mclk) disable iff (!rst_n)
        (fb.stop && |vld_q && !busy_q) |=> busy_q && vld_q == '0)
        else $error("stop did not start the write cycle");
    AST_WP_REJECT: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_RX && kind_q == K_DATA && byte_end && wp_lat_q)
        |=> state_q == ST_IDLE && !sda_oe_q && vld_q == '0)
        else $error("protected data byte was accepted");
    AST_RD_WRAP: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_TX && byte_end)
        |=> addr_q == (($past(addr_q) == AW'(DEPTH - 1)) ? AW'(0) : AW'($past(addr_q) + 1)))
        else $error("read address did not advance");
    AST_QUIET_BUSY: assert property (@(posedge mclk) disable iff (!rst_n)
        busy_q |-> !sda_oe_q)
        else $error("data line driven during write cycle");
    AST_DRIVE_EDGE: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(sda_oe_q) |-> $past(fb.scl_fall || fb.start || fb.stop))
        else $error("data line changed away from a falling clock");
    AST_WP_SAMPLE: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_ACK && kind_q == K_WORD && fb.scl_fall && !fb.start && !fb.stop)
        |=> wp_lat_q == $past(fb.wp_s))
        else $error("protect level not sampled before first data");
    AST_BUSY_END: assert property (@(posedge mclk) disable iff (!rst_n)
        (busy_q && cnt_q == '0 && !commit) |=> !busy_q)
        else $error("write cycle did not end on time");
endmodule : eeops_top
`default_nettype wire

// ===== include/eeops_pkg.sv
// shared constants and types for the serial eeprom slave operation logic
package eeops_pkg;
    localparam int CLK_MHZ = 100;
    localparam int WRITE_CYCLE_TIME_MS = 5;
    localparam int INTERNAL_WRITE_CYCLE_TIME_DEF = WRITE_CYCLE_TIME_MS * 1000 * CLK_MHZ;
    localparam int DEPTH_DEF = 1024;
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_AW = 4;
    localparam logic [3:0] DEV_CODE = 4'hA;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int UPPER_HIGH_POS = 2;
    localparam int UPPER_LOW_POS = 1;
    localparam int RW_POS = 0;

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} eeops_state_t;
    typedef enum logic [1:0] {K_DEV, K_WORD, K_DATA} eeops_kind_t;
endpackage : eeops_pkg

// ===== include/eeops_if.sv
// bus events passed from the pin front end to the operation core
`timescale 1ns/1ps
`default_nettype none
interface eeops_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda_s;
    logic wp_s;
    modport fe (output scl_rise, output scl_fall, output start, output stop, output sda_s, output wp_s);
    modport core (input scl_rise, input scl_fall, input start, input stop, input sda_s, input wp_s);
endinterface : eeops_if
`default_nettype wire

// ===== rtl/eeops_fe.sv
// pin synchronisers and edge, start and stop detection
`timescale 1ns/1ps
`default_nettype none
module eeops_fe
    import eeops_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_pin,
    input wire logic sda_pin,
    input wire logic wp_pin,
    eeops_if.fe fb
);
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [1:0] wp_q;

    // stage 0 feeds stage 1 only; edges are taken between stages 1 and 2
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            wp_q <= 2'h0;
        end else begin
            scl_q <= {scl_q[1:0], scl_pin};
            sda_q <= {sda_q[1:0], sda_pin};
            wp_q <= {wp_q[0], wp_pin};
        end
    end

    assign fb.scl_rise = scl_q[1] & ~scl_q[2];
    assign fb.scl_fall = ~scl_q[1] & scl_q[2];
    assign fb.start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    assign fb.stop = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
    assign fb.sda_s = sda_q[1];
    assign fb.wp_s = wp_q[1];
endmodule : eeops_fe
`default_nettype wire

// ===== bench/eeops_master.sv
// two-wire bus master model facing the eeprom slave
`timescale 1ns/1ps
`default_nettype none
module eeops_master (
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    // idle bus: clock and data stand high between frames
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // low 75 ns, high 50 ns: the data changes well after the slave lets go
    // every pin move is kept 2 ns off the 5 ns grid so none lands on an mclk edge
    task automatic bit_out(input logic b);
        #((7 - $time % 5) % 5);
        #45 sda_m = b;
        #30 scl = 1'b1;
        #50 scl = 1'b0;
    endtask : bit_out
    task automatic bit_in(output logic b);
        #((7 - $time % 5) % 5);
        #45 sda_m = 1'b1;
        #30 scl = 1'b1;
        #50 b = sda;
        scl = 1'b0;
    endtask : bit_in
    // long lead-in so a slave ack is gone before the data line moves with clock high
    task automatic start_c();
        #((7 - $time % 5) % 5);
        #125 sda_m = 1'b1;
        #30 scl = 1'b1;
        #50 sda_m = 1'b0;
        #50 scl = 1'b0;
    endtask : start_c
    task automatic stop_c();
        #((7 - $time % 5) % 5);
        #125 sda_m = 1'b0;
        #30 scl = 1'b1;
        #50 sda_m = 1'b1;
        #125;
    endtask : stop_c
    task automatic wr(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_out(b[i]);
        bit_in(r);
        ack = ~r;
    endtask : wr
    task automatic rd(output logic [7:0] b, input logic mack);
        for (int i = 7; i >= 0; i--) bit_in(b[i]);
        bit_out(~mack);
    endtask : rd
endmodule : eeops_master
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the eeprom slave operation logic
`timescale 1ns/1ps
`default_nettype none
module tb
    import eeops_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic wp = 1'b0;
    logic scl, sda_m, sda_o, sda_oe, busy, sda;
    int errors = 0;
    int tests_run = 0;
    always #5 mclk = ~mclk;
    // open drain wire with pull-up
    assign sda = (sda_oe ? sda_o : 1'b1) & sda_m;
    eeops_top #(.DEPTH(1024), .INTERNAL_WRITE_CYCLE_TIME(200)) dut (
        .mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .wp(wp), .busy(busy));
    eeops_master m (.scl(scl), .sda_m(sda_m), .sda(sda));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [7:0] dev(input logic [9:0] a, input logic rw);
        return {DEV_CODE, 1'b0, a[9:8], rw};
    endfunction : dev
    task automatic set_addr(input logic [9:0] a);
        logic ack;
        m.start_c();
        m.wr(dev(a, 1'b0), ack);
        chk("dev ack", 8'h01, 8'(ack));
        m.wr(a[7:0], ack);
        chk("word ack", 8'h01, 8'(ack));
    endtask : set_addr
    task automatic rd_from(input logic [9:0] a);
        logic ack;
        set_addr(a);
        m.start_c();
        m.wr(dev(a, 1'b1), ack);
        chk("read dev ack", 8'h01, 8'(ack));
    endtask : rd_from
    task automatic poll(output int nacks);
        logic ack;
        nacks = 0;
        ack = 1'b0;
        while (ack !== 1'b1 && nacks < 50) begin
            m.start_c();
            m.wr(dev(10'h000, 1'b0), ack);
            if (ack !== 1'b1) begin
                nacks++;
                m.stop_c();
            end
        end
        chk("poll ack", 8'h01, 8'(ack));
        m.stop_c();
    endtask : poll
    task automatic t_page();
        logic ack;
        logic [7:0] b;
        int n;
        set_addr(10'h12E);
        // 18 bytes from offset 14: the last two land on offsets 14 and 15 again
        for (int i = 0; i < 18; i++) begin
            m.wr(8'h10 + 8'(i), ack);
            chk("page data ack", 8'h01, 8'(ack));
        end
        m.stop_c();
        chk("busy after stop", 8'h01, 8'(busy));
        poll(n);
        chk("polls refused", 8'h01, 8'(n > 0));
        rd_from(10'h120);
        for (int o = 0; o < 16; o++) begin
            m.rd(b, o < 15);
            chk("page byte", 8'h12 + 8'(o), b);
        end
        m.stop_c();
        chk("released after read", 8'h00, 8'(sda_oe));
    endtask : t_page
    task automatic t_roll();
        logic ack;
        logic [7:0] b;
        int n;
        set_addr(10'h000);
        m.wr(8'h5A, ack);
        m.stop_c();
        poll(n);
        rd_from(10'h3FF);
        m.rd(b, 1'b1);
        chk("last byte", ERASED_BYTE, b);
        m.rd(b, 1'b0);
        chk("wrapped byte", 8'h5A, b);
        m.stop_c();
        m.start_c();
        m.wr(dev(10'h000, 1'b1), ack);
        chk("immediate ack", 8'h01, 8'(ack));
        m.rd(b, 1'b0);
        chk("current byte", ERASED_BYTE, b);
        m.stop_c();
    endtask : t_roll
    task automatic t_wp();
        logic ack;
        logic [7:0] b;
        int n;
        @(negedge mclk) wp = 1'b1;
        set_addr(10'h000);
        m.wr(8'h33, ack);
        chk("protected data ack", 8'h00, 8'(ack));
        m.stop_c();
        chk("busy when protected", 8'h00, 8'(busy));
        @(negedge mclk) wp = 1'b0;
        set_addr(10'h001);
        m.wr(8'h77, ack);
        chk("unprotected data ack", 8'h01, 8'(ack));
        // protect raised after the strobe must not stop this session
        @(negedge mclk) wp = 1'b1;
        m.wr(8'h78, ack);
        chk("late protect ack", 8'h01, 8'(ack));
        m.stop_c();
        @(negedge mclk) wp = 1'b0;
        poll(n);
        rd_from(10'h000);
        for (int i = 0; i < 3; i++) begin
            m.rd(b, i < 2);
            chk("protect result", (i == 0) ? 8'h5A : 8'h76 + 8'(i), b);
        end
        m.stop_c();
    endtask : t_wp
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        repeat (5) @(negedge mclk);
        t_page();
        t_roll();
        t_wp();
        wrap_up();
    end
    // about 100 us of traffic is expected
    initial begin
        #500000;
        errors++;
        wrap_up();
    end
endmodule : tb
`default_nettype wire
